// ===== hw/bps_pkg.sv
// Constants and types shared by the bank program sequencer
// Notes on behaviour
// - Last bank comes from a setting of 0 to 7, default 7.
// - A finished bank hands over to the next; start is allowed in any valid bank.
// - Launch on cleared-to-launched, stop on launched-to-cleared; clear works anywhere.
// - Launch continues from current bank, issues run, drives program end low.
// - Clear forces bank 0, issues stop, drives program end low.
// - While running, bank index steps by one when its soak time elapses.
// - End pattern OFF means the program never executes.
// - Halt pattern: after last bank, end, go stopped, program end high.
// - Hold pattern: after last bank, end, keep running, program end high.
// - Wrap pattern: after last bank, bank returns to 0 and execution continues.
// - Banks with zero soak time are skipped.
// - Bank changes accepted while running; pattern change resets bank to 0.
// - Soak time 0 to 9999 units, default 1; unit minutes, hours or seconds.
// - Soak timer advances only while process value is within set point +- band.
// - Band OFF counts as infinite, so timing runs continuously.
// - With launch on an event input, key changes to launch state are rejected.
// - Pattern set to OFF clears the event input launch assignment.
// - After power loss the launch and run states are restored.
// - After power loss the soak timer restarts from zero.
// - Event input change while off alters neither run state nor bank at power-up.
// - Soak time and band changes act on the bank now executing.
// - A bank change discards accumulated soak time and times afresh.
// - Program end output clears when the program is cleared.
package bps_pkg;
  localparam logic [1:0]  BPS_PAT_OFF    = 2'h0;
  localparam logic [1:0]  BPS_PAT_HALT   = 2'h1;
  localparam logic [1:0]  BPS_PAT_HOLD   = 2'h2;
  localparam logic [1:0]  BPS_PAT_WRAP   = 2'h3;
  localparam logic [1:0]  BPS_UNIT_MIN   = 2'h0;
  localparam logic [1:0]  BPS_UNIT_HOUR  = 2'h1;
  localparam logic [1:0]  BPS_UNIT_SEC   = 2'h2;
  localparam int          BPS_BANK_W     = 3;
  localparam int          BPS_NBANK      = 8;
  localparam int          BPS_SOAK_W     = 14;
  localparam logic [2:0]  BPS_LAST_DFLT  = 3'h7;
  localparam logic [13:0] BPS_SOAK_DFLT  = 14'h0001;
  localparam logic [13:0] BPS_SOAK_MAX   = 14'h270F;
  localparam logic [15:0] BPS_BAND_OFF   = 16'h0000;
  localparam int          BPS_CLK_NS     = 40;
  localparam int          BPS_SEC_NS     = 1000000000;
  localparam int          BPS_CYC_PER_SEC = BPS_SEC_NS / BPS_CLK_NS;
  localparam logic [11:0] BPS_SEC_PER_MIN  = 12'h03C;
  localparam logic [11:0] BPS_SEC_PER_HOUR = 12'hE10;
  localparam logic [1:0]  BPS_BOOT_CYC   = 2'h3;
  localparam logic [2:0]  BPS_BANK_RST   = 3'h0;
  localparam logic [13:0] BPS_CNT_RST    = 14'h0000;

  typedef enum logic [1:0] {ST_BOOT, ST_CLEARED, ST_EXEC, ST_ENDED} bps_state_t;

  // Absolute distance of process value from set point
  function automatic logic [16:0] bps_dist(input logic signed [15:0] a,
                                           input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    return d[16] ? 17'(-d) : 17'(d);
  endfunction
endpackage

// ===== hw/bps_soak_tick.sv
// Soak timebase: one tick per soak unit derived from the system clock
`timescale 1ns/1ps
module bps_soak_tick
  import bps_pkg::*;
#(
  parameter int CYC_PER_SEC = BPS_CYC_PER_SEC
)(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       restart_i,
  input  wire logic [1:0] unit_i,
  output logic            tick_o
);
  logic [31:0] pre_q;
  logic [11:0] sec_q;
  logic [11:0] secs_per_unit;
  logic        sec_pulse;

  // Seconds per unit; an unknown code falls back to minutes
  always_comb
  begin
    if (unit_i == BPS_UNIT_HOUR)
      secs_per_unit = BPS_SEC_PER_HOUR;
    else if (unit_i == BPS_UNIT_SEC)
      secs_per_unit = 12'h001;
    else
      secs_per_unit = BPS_SEC_PER_MIN;
  end

  assign sec_pulse = (pre_q == 32'(CYC_PER_SEC - 1));

  // Prescaler to one second; restart keeps a fresh unit full length
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pre_q <= 32'h0000_0000;
    else if (restart_i || sec_pulse)
      pre_q <= 32'h0000_0000;
    else
      pre_q <= pre_q + 32'h0000_0001;
  end

  // Seconds within the unit
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sec_q <= 12'h000;
    else if (restart_i)
      sec_q <= 12'h000;
    else if (sec_pulse)
      sec_q <= (sec_q >= secs_per_unit - 12'h001) ? 12'h000
                                                   : sec_q + 12'h001;
  end

  assign tick_o = sec_pulse && (sec_q >= secs_per_unit - 12'h001);
endmodule

// ===== hw/bps_sequencer.sv
// Bank program sequencer: launch/clear, soak timing and end patterns
`timescale 1ns/1ps
module bps_sequencer
  import bps_pkg::*;
#(
  parameter int CYC_PER_SEC = BPS_CYC_PER_SEC
)(
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_n_i,
  input  wire logic [1:0]             end_pattern_i,
  input  wire logic [2:0]             last_bank_i,
  input  wire logic [7:0][13:0]       soak_time_i,
  input  wire logic [1:0]             soak_unit_i,
  input  wire logic [15:0]            wait_band_i,
  input  wire logic signed [15:0]     pv_i,
  input  wire logic signed [15:0]     sp_i,
  input  wire logic                   key_launch_i,
  input  wire logic                   key_clear_i,
  input  wire logic                   comm_launch_i,
  input  wire logic                   comm_clear_i,
  input  wire logic                   evt_assigned_i,
  input  wire logic                   evt_launch_pin_i,
  input  wire logic                   bank_set_i,
  input  wire logic [2:0]             bank_sel_i,
  input  wire logic                   nv_launched_i,
  input  wire logic                   nv_running_i,
  input  wire logic                   nv_ended_i,
  input  wire logic [2:0]             nv_bank_i,
  output logic                        program_launch_setting_o,
  output logic                        running_o,
  output logic                        prog_end_o,
  output logic [2:0]                  bank_o,
  output logic [13:0]                 soak_remaining_monitor_o,
  output logic                        run_cmd_o,
  output logic                        stop_cmd_o,
  output logic                        evt_assign_clear_o,
  output logic                        key_rejected_o
);
  bps_state_t  state_q;
  logic [1:0]  boot_q;
  logic        evt_meta_q;
  logic        evt_sync_q;
  logic        evt_prev_q;
  logic [1:0]  pat_q;
  logic [2:0]  bank_q;
  logic        running_q;
  logic        end_q;
  logic [13:0] count_q;
  logic [13:0] remain_q;
  logic        run_cmd_q;
  logic        stop_cmd_q;
  logic        asg_clr_q;
  logic        key_rej_q;
  logic        booting;
  logic        boot_done;
  logic        launched;
  logic        evt_rise;
  logic        evt_fall;
  logic        launch_req;
  logic        clear_req;
  logic        pat_chg;
  logic        to_off;
  logic        clear_acc;
  logic        launch_acc;
  logic        bank_acc;
  logic [13:0] soak_cur;
  logic        at_last;
  logic        in_band;
  logic        adv;
  logic        finish_stop;
  logic        cnt_restart;
  logic        tick;

  // Event pin crosses in through two flops before anything reads it
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      evt_meta_q <= 1'b0;
      evt_sync_q <= 1'b0;
    end
    else
    begin
      evt_meta_q <= evt_launch_pin_i;
      evt_sync_q <= evt_meta_q;
    end
  end

  // Previous event level; follows the synchronised pin through boot, with edges masked while booting, so an edge made while
  // powered off is not seen as a launch or clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      evt_prev_q <= 1'b0;
    else
      evt_prev_q <= evt_sync_q;
  end

  // Boot delay covers the synchroniser fill before state is restored
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      boot_q <= 2'h0;
    else if (booting)
      boot_q <= boot_q + 2'h1;
  end

  assign booting   = (state_q == ST_BOOT);
  assign boot_done = booting && (boot_q == BPS_BOOT_CYC);
  assign launched  = (state_q == ST_EXEC) || (state_q == ST_ENDED);

  // Request decode: event input owns launch when assigned
  assign evt_rise   = evt_sync_q && !evt_prev_q && !booting;
  assign evt_fall   = !evt_sync_q && evt_prev_q && !booting;
  assign launch_req = evt_assigned_i ? evt_rise
                                     : (key_launch_i || comm_launch_i);
  assign clear_req  = evt_assigned_i ? evt_fall
                                     : (key_clear_i || comm_clear_i);
  assign pat_chg    = !booting && (end_pattern_i != pat_q);
  assign to_off     = pat_chg && (end_pattern_i == BPS_PAT_OFF);
  assign clear_acc  = !booting && !pat_chg && clear_req && launched;
  assign launch_acc = !booting && !pat_chg && !clear_req && launch_req
                      && (state_q == ST_CLEARED)
                      && (end_pattern_i != BPS_PAT_OFF);
  assign bank_acc   = !booting && !pat_chg && !clear_acc && !launch_acc
                      && bank_set_i && (bank_sel_i <= last_bank_i);

  // Live soak and band inputs, so adjustments hit the current bank
  assign soak_cur = soak_time_i[bank_q];
  assign at_last  = (bank_q >= last_bank_i);
  assign in_band  = (wait_band_i == BPS_BAND_OFF)
                    || (bps_dist(pv_i, sp_i) <= {1'b0, wait_band_i});

  // Bank finished: zero soak skips at once, else count reached
  assign adv = (state_q == ST_EXEC) && !pat_chg && !clear_acc && !bank_acc
               && ((soak_cur == 14'h0000) || (count_q >= soak_cur));
  assign finish_stop = adv && at_last && (end_pattern_i == BPS_PAT_HALT);
  assign cnt_restart = booting || pat_chg || launch_acc || bank_acc
                       || adv;

  bps_soak_tick #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_tick (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .restart_i   (cnt_restart),
    .unit_i      (soak_unit_i),
    .tick_o      (tick)
  );

  // Program state machine
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_q <= ST_BOOT;
    else
    begin
      case (state_q)
        ST_BOOT:
          if (boot_done)
          begin
            if (!nv_launched_i || end_pattern_i == BPS_PAT_OFF)
              state_q <= ST_CLEARED;
            else
              state_q <= nv_ended_i ? ST_ENDED : ST_EXEC;
          end
        ST_CLEARED:
          if (launch_acc)
            state_q <= ST_EXEC;
        default:
          if (to_off || clear_acc)
            state_q <= ST_CLEARED;
          else if (adv && at_last && end_pattern_i != BPS_PAT_WRAP)
            state_q <= ST_ENDED;
      endcase
    end
  end

  // Last pattern seen; a difference is a pattern change
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pat_q <= BPS_PAT_OFF;
    else
      pat_q <= end_pattern_i;
  end

  // Bank index
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bank_q <= BPS_BANK_RST;
    else if (boot_done)
      bank_q <= nv_bank_i;
    else if (pat_chg || clear_acc)
      bank_q <= BPS_BANK_RST;
    else if (bank_acc)
      bank_q <= bank_sel_i;
    else if (adv)
    begin
      if (!at_last)
        bank_q <= bank_q + 3'h1;
      else if (end_pattern_i == BPS_PAT_WRAP)
        bank_q <= BPS_BANK_RST;
    end
  end

  // Run or stop state
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      running_q <= 1'b0;
    else if (boot_done)
      running_q <= nv_running_i;
    else if ((to_off && launched) || clear_acc || finish_stop)
      running_q <= 1'b0;
    else if (launch_acc)
      running_q <= 1'b1;
  end

  // Program end output
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      end_q <= 1'b0;
    else if (boot_done)
      end_q <= nv_launched_i && nv_ended_i
               && (end_pattern_i != BPS_PAT_OFF);
    else if (pat_chg || clear_acc || launch_acc)
      end_q <= 1'b0;
    else if (adv && at_last && end_pattern_i != BPS_PAT_WRAP)
      end_q <= 1'b1;
  end

  // Soak count; saturates at the largest soak setting
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_q <= BPS_CNT_RST;
    else if (cnt_restart)
      count_q <= BPS_CNT_RST;
    else if (state_q == ST_EXEC && tick && in_band
             && count_q < BPS_SOAK_MAX)
      count_q <= count_q + 14'h0001;
  end

  // Remaining time monitor; lowered soak below count reads zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      remain_q <= BPS_CNT_RST;
    else
      remain_q <= (count_q >= soak_cur) ? BPS_CNT_RST : soak_cur - count_q;
  end

  // One-cycle command pulses toward the controller core
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      run_cmd_q  <= 1'b0;
      stop_cmd_q <= 1'b0;
      asg_clr_q  <= 1'b0;
      key_rej_q  <= 1'b0;
    end
    else
    begin
      run_cmd_q  <= launch_acc;
      stop_cmd_q <= clear_acc || finish_stop || (to_off && launched);
      asg_clr_q  <= to_off;
      key_rej_q  <= !booting && evt_assigned_i
                    && (key_launch_i || key_clear_i);
    end
  end

  assign program_launch_setting_o = launched;
  assign running_o                = running_q;
  assign prog_end_o               = end_q;
  assign bank_o                   = bank_q;
  assign soak_remaining_monitor_o = remain_q;
  assign run_cmd_o                = run_cmd_q;
  assign stop_cmd_o               = stop_cmd_q;
  assign evt_assign_clear_o       = asg_clr_q;
  assign key_rejected_o           = key_rej_q;

  // Checks on the sequencing
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_launch;
    launch_acc |=> state_q == ST_EXEC && running_q && !end_q && run_cmd_q;
  endproperty
  a_launch: assert property (p_launch) else $error("launch failed");

  property p_clear;
    clear_acc |=> bank_q == 3'h0 && !running_q && !end_q && stop_cmd_q;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_off;
    end_pattern_i == BPS_PAT_OFF |=> state_q != ST_EXEC;
  endproperty
  a_off: assert property (p_off) else $error("executing with OFF");

  property p_halt;
    adv && at_last && end_pattern_i == BPS_PAT_HALT
      |=> state_q == ST_ENDED && !running_q && end_q && stop_cmd_q;
  endproperty
  a_halt: assert property (p_halt) else $error("halt end wrong");

  property p_hold;
    adv && at_last && end_pattern_i == BPS_PAT_HOLD && running_q
      |=> state_q == ST_ENDED && running_q && end_q;
  endproperty
  a_hold: assert property (p_hold) else $error("hold end wrong");

  property p_wrap;
    adv && at_last && end_pattern_i == BPS_PAT_WRAP
      |=> bank_q == 3'h0 && state_q == ST_EXEC && !end_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap wrong");

  property p_step;
    adv && !at_last |=> bank_q == $past(bank_q) + 3'h1 && count_q == 14'h0;
  endproperty
  a_step: assert property (p_step) else $error("bank step wrong");

  property p_pause;
    state_q == ST_EXEC && !in_band && !cnt_restart |=> $stable(count_q);
  endproperty
  a_pause: assert property (p_pause) else $error("timer ran out of band");

  property p_pat_chg;
    pat_chg |=> bank_q == 3'h0 && count_q == 14'h0;
  endproperty
  a_pat_chg: assert property (p_pat_chg) else $error("pattern chg");

  property p_asg_clr;
    to_off |=> evt_assign_clear_o ##1 !evt_assign_clear_o;
  endproperty
  a_asg_clr: assert property (p_asg_clr) else $error("assign clear");

  property p_key_rej;
    state_q == ST_CLEARED && evt_assigned_i && !evt_rise && !pat_chg
      |=> state_q == ST_CLEARED;
  endproperty
  a_key_rej: assert property (p_key_rej) else $error("key launched");

  property p_skip;
    state_q == ST_EXEC && soak_cur == 14'h0 && !at_last && !pat_chg
      && !clear_acc && !bank_acc |=> bank_q != $past(bank_q);
  endproperty
  a_skip: assert property (p_skip) else $error("zero bank kept");

  c_halt_end: cover property (finish_stop);
  c_wrap: cover property (adv && at_last && end_pattern_i == BPS_PAT_WRAP);
  c_bank_set: cover property (bank_acc && state_q == ST_EXEC);
endmodule

// ===== testbench/bps_panel_model.sv
// Operator keys, event input, host commands and retention memory model
`timescale 1ns/1ps
module bps_panel_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       launched_i,
  input  wire logic       running_i,
  input  wire logic       ended_i,
  input  wire logic [2:0] bank_i,
  output logic [4:0]      req_o,
  output logic [2:0]      bank_sel_o,
  output logic            evt_assigned_o,
  output logic            evt_pin_o,
  output logic            nv_launched_o,
  output logic            nv_running_o,
  output logic            nv_ended_o,
  output logic [2:0]      nv_bank_o
);
  logic [3:0] up_q;

  // Idle panel at time zero
  initial
  begin
    req_o = 5'h00;
    bank_sel_o = 3'h0;
    evt_assigned_o = 1'b0;
    evt_pin_o = 1'b0;
    nv_launched_o = 1'b0;
    nv_running_o = 1'b0;
    nv_ended_o = 1'b0;
    nv_bank_o = 3'h0;
  end

  // One-cycle request; bits: key launch, key clear, host launch,
  // host clear, bank set
  task automatic press(input int idx, input logic [2:0] sel);
    if (idx == 2 && evt_assigned_o)
      return;
    @(posedge clk_sys_i);
    req_o[idx] <= 1'b1;
    bank_sel_o <= sel;
    @(posedge clk_sys_i);
    req_o[idx] <= 1'b0;
    bank_sel_o <= ~sel; // Released select carries junk, not the old value
  endtask

  // Event input wiring and level
  task automatic set_evt(input logic asg, input logic pin);
    @(posedge clk_sys_i);
    evt_assigned_o <= asg;
    evt_pin_o <= pin;
  endtask

  // Settle counter after power-up
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      up_q <= 4'h0;
    else if (up_q != 4'hF)
      up_q <= up_q + 4'h1;
  end

  // Retention memory frozen through reset and boot, so the design
  // reads the pre-interruption state and not its own boot zeros
  always @(posedge clk_sys_i)
  begin
    if (rst_n_i && up_q == 4'hF)
    begin
      nv_launched_o <= launched_i;
      nv_running_o <= running_i;
      nv_ended_o <= ended_i;
      nv_bank_o <= bank_i;
    end
  end
endmodule

// ===== testbench/bps_sequencer_test.sv
// Self-checking bench for the bank program sequencer
`timescale 1ns/1ps
module bps_sequencer_test;
  import bps_pkg::*;
  logic               clk_sys_i;
  logic               rst_n_i;
  logic [1:0]         pat;
  logic [2:0]         last;
  logic [7:0][13:0]   soak;
  logic [15:0]        band;
  logic signed [15:0] pv;
  logic [4:0]         req;
  logic [2:0]         sel;
  logic               asg;
  logic               pin;
  logic               nv_l;
  logic               nv_r;
  logic               nv_e;
  logic [2:0]         nv_b;
  logic               launched;
  logic               running;
  logic               pend;
  logic               run_c;
  logic               stop_c;
  logic               aclr;
  logic               rej;
  logic [2:0]         bank;
  logic [13:0]        remain;
  logic [1:0]         unit;
  int                 failures = 0;
  int                 samples_checked = 0;
  int                 n_run = 0;
  int                 n_stop = 0;
  int                 n_aclr = 0;
  int                 n_rej = 0;
  int                 n_b1 = 0;

  // Short timebase: four cycles per second keeps soak runs brief
  bps_sequencer #(.CYC_PER_SEC(4)) bps_sequencer_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .end_pattern_i(pat),
    .last_bank_i(last), .soak_time_i(soak), .soak_unit_i(unit),
    .wait_band_i(band), .pv_i(pv), .sp_i(16'sh0000),
    .key_launch_i(req[0]), .key_clear_i(req[1]),
    .comm_launch_i(req[2]), .comm_clear_i(req[3]),
    .evt_assigned_i(asg), .evt_launch_pin_i(pin), .bank_set_i(req[4]),
    .bank_sel_i(sel), .nv_launched_i(nv_l), .nv_running_i(nv_r),
    .nv_ended_i(nv_e), .nv_bank_i(nv_b),
    .program_launch_setting_o(launched), .running_o(running),
    .prog_end_o(pend), .bank_o(bank), .soak_remaining_monitor_o(remain),
    .run_cmd_o(run_c), .stop_cmd_o(stop_c),
    .evt_assign_clear_o(aclr), .key_rejected_o(rej));

  bps_panel_model bps_panel_model_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .launched_i(launched),
    .running_i(running), .ended_i(pend), .bank_i(bank), .req_o(req),
    .bank_sel_o(sel), .evt_assigned_o(asg), .evt_pin_o(pin),
    .nv_launched_o(nv_l), .nv_running_o(nv_r), .nv_ended_o(nv_e),
    .nv_bank_o(nv_b));

  // 25 MHz clock
  always #20 clk_sys_i = ~clk_sys_i;

  // Pulse counters, so one-cycle strobes are never missed between checks
  always @(posedge clk_sys_i)
  begin
    n_run <= n_run + int'(run_c === 1'b1);
    n_stop <= n_stop + int'(stop_c === 1'b1);
    n_aclr <= n_aclr + int'(aclr === 1'b1);
    n_rej <= n_rej + int'(rej === 1'b1);
    n_b1 <= n_b1 + int'(bank === 3'h1);
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bounded wait for a bank and end-output pair, then judge it
  task automatic wait_for(input logic [2:0] b, input logic e, input int mx);
    int k;
    k = 0;
    while (!(bank === b && pend === e) && k < mx)
    begin
      cyc(1);
      k++;
    end
    chk("bank", {13'h0, b}, {13'h0, bank});
    chk("end out", {15'h0, e}, {15'h0, pend});
  endtask

  task automatic set_pat(input logic [1:0] p);
    @(posedge clk_sys_i);
    pat <= p;
    cyc(3);
  endtask

  task automatic t_off();
    int a0;
    a0 = n_aclr;
    bps_panel_model_i.press(0, 3'h0);
    cyc(3);
    chk("launch off", 16'h0, {15'h0, launched});
    chk("run off", 16'h0, {15'h0, running});
    set_pat(BPS_PAT_HALT);
    set_pat(BPS_PAT_OFF);
    chk("assign clear", 16'h1, 16'(n_aclr - a0));
    $display("t_off done");
  endtask

  task automatic t_halt();
    int r0;
    int s0;
    int b0;
    @(posedge clk_sys_i);
    last <= 3'h2;
    soak[1] <= 14'h0000;
    set_pat(BPS_PAT_HALT);
    r0 = n_run;
    s0 = n_stop;
    b0 = n_b1;
    bps_panel_model_i.press(0, 3'h0);
    cyc(2);
    chk("run", 16'h1, {15'h0, running});
    chk("end low", 16'h0, {15'h0, pend});
    chk("run cmd", 16'h1, 16'(n_run - r0));
    wait_for(3'h2, 1'b1, 60);
    cyc(1); // Stop pulse reaches its counter one edge later
    chk("zero soak skip", 16'h0, 16'(n_b1 - b0 > 2));
    chk("halt run", 16'h0, {15'h0, running});
    chk("halt stop", 16'h1, 16'(n_stop - s0));
    s0 = n_stop;
    bps_panel_model_i.press(1, 3'h0);
    cyc(2);
    chk("clear end", 16'h0, {15'h0, pend});
    chk("clear bank", 16'h0, {13'h0, bank});
    chk("clear stop", 16'h1, 16'(n_stop - s0));
    chk("cleared", 16'h0, {15'h0, launched});
    @(posedge clk_sys_i);
    soak[1] <= 14'h0002;
    $display("t_halt done");
  endtask

  task automatic t_wrap_hold();
    @(posedge clk_sys_i);
    last <= 3'h1;
    set_pat(BPS_PAT_WRAP);
    bps_panel_model_i.press(2, 3'h0);
    cyc(2);
    chk("host launch", 16'h1, {15'h0, launched});
    wait_for(3'h1, 1'b0, 40);
    wait_for(3'h0, 1'b0, 40);
    chk("wrap run", 16'h1, {15'h0, running});
    bps_panel_model_i.press(4, 3'h1);
    cyc(2);
    chk("bank set", 16'h1, {13'h0, bank});
    set_pat(BPS_PAT_HOLD);
    chk("pattern bank", 16'h0, {13'h0, bank});
    wait_for(3'h1, 1'b1, 60);
    chk("hold run", 16'h1, {15'h0, running});
    bps_panel_model_i.press(3, 3'h0);
    cyc(2);
    chk("host clear", 16'h0, {15'h0, launched});
    chk("end cleared", 16'h0, {15'h0, pend});
    $display("t_wrap_hold done");
  endtask

  task automatic t_band();
    @(posedge clk_sys_i);
    band <= 16'h0005;
    pv <= 16'sh0064;
    bps_panel_model_i.press(0, 3'h0);
    cyc(30);
    chk("out of band", 16'h0, {13'h0, bank});
    chk("remaining", 16'h0002, {2'h0, remain});
    @(posedge clk_sys_i);
    pv <= 16'sh0003;
    wait_for(3'h1, 1'b0, 30);
    bps_panel_model_i.press(1, 3'h0);
    @(posedge clk_sys_i);
    band <= BPS_BAND_OFF;
    pv <= 16'sh0000;
    cyc(2);
    $display("t_band done");
  endtask

  // Minute unit: two-minute soak is 480 cycles at this timebase
  task automatic t_unit();
    @(posedge clk_sys_i);
    unit <= BPS_UNIT_MIN;
    bps_panel_model_i.press(0, 3'h0);
    cyc(400);
    chk("minute hold", 16'h0, {13'h0, bank});
    wait_for(3'h1, 1'b0, 120);
    bps_panel_model_i.press(1, 3'h0);
    @(posedge clk_sys_i);
    unit <= BPS_UNIT_SEC;
    cyc(2);
    $display("t_unit done");
  endtask

  task automatic t_evt();
    int j0;
    bps_panel_model_i.set_evt(1'b1, 1'b0);
    j0 = n_rej;
    bps_panel_model_i.press(0, 3'h0);
    cyc(2);
    chk("key reject", 16'h1, 16'(n_rej - j0));
    chk("no key launch", 16'h0, {15'h0, launched});
    bps_panel_model_i.set_evt(1'b1, 1'b1);
    cyc(5);
    chk("event launch", 16'h1, {15'h0, launched});
    chk("event run", 16'h1, {15'h0, running});
    bps_panel_model_i.set_evt(1'b1, 1'b0);
    cyc(5);
    chk("event clear", 16'h0, {15'h0, launched});
    bps_panel_model_i.set_evt(1'b0, 1'b0);
    $display("t_evt done");
  endtask

  task automatic t_power();
    bps_panel_model_i.press(0, 3'h0);
    wait_for(3'h1, 1'b0, 40);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    cyc(5);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    cyc(8);
    chk("kept launch", 16'h1, {15'h0, launched});
    chk("kept run", 16'h1, {15'h0, running});
    chk("kept bank", 16'h1, {13'h0, bank});
    bps_panel_model_i.press(1, 3'h0);
    cyc(2);
    $display("t_power done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, well beyond the seven hundred or so cycles the tests need
  initial
  begin
    repeat (4000) @(posedge clk_sys_i);
    failures++;
    tally_and_finish();
  end

  // Main sequence; pattern OFF at release so boot sees no change
  initial
  begin
    clk_sys_i = 1'b0;
    rst_n_i = 1'b0;
    pat = BPS_PAT_OFF;
    last = BPS_LAST_DFLT;
    soak = {8{14'h0002}};
    band = BPS_BAND_OFF;
    pv = 16'sh0000;
    unit = BPS_UNIT_SEC;
    cyc(5);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    cyc(10);
    t_off();
    t_halt();
    t_wrap_hold();
    t_band();
    t_unit();
    t_evt();
    t_power();
    tally_and_finish();
  end
endmodule
